// *** rtl/dmod_consts.svh ***
// Register map, field positions and reset values of the modulator
`ifndef DMOD_CONSTS_SVH
`define DMOD_CONSTS_SVH
// Byte offsets on the register bus
`define DMOD_OFS_CTRL   4'h0
`define DMOD_OFS_SRC    4'h4
`define DMOD_OFS_HIGH_TIME_CARRIER   4'h8
`define DMOD_OFS_LOW_TIME_CARRIER   4'hC
// Control register fields
`define DMOD_EN_BIT     7
`define DMOD_OINV_BIT   4
`define DMOD_STAT_BIT   3
`define DMOD_SWBIT_BIT  0
// Carrier control register fields
`define DMOD_CINV_BIT   6
`define DMOD_CSYNC_BIT  5
`define DMOD_SEL_MSB    3
// Source codes and widths
`define DMOD_SEL_W      4
`define DMOD_NSRC       16
`define DMOD_SEL_SW     4'h0
`define DMOD_CAR_GND    4'h0
`define DMOD_CAR_RSVD   4'h9
// Reset values
`define DMOD_CTRL_RST   8'h00
`define DMOD_SEL_RST    4'h0
`endif

// *** rtl/dmod_pkg.sv ***
// Types shared by the modulator modules
package dmod_pkg;
`include "dmod_consts.svh"
  typedef logic [`DMOD_SEL_W-1:0] dmod_sel_t;
  typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} dmod_bus_t;
  // Selector state: two sync stages and the chosen bit
  typedef struct packed {
    logic [`DMOD_NSRC-1:0] s1;
    logic [`DMOD_NSRC-1:0] s2;
    logic                  pick;
  } dmod_sel_st_t;
  // Top-level state
  typedef struct packed {
    logic      en;
    logic      out_inv;
    logic      sw_bit;
    dmod_sel_t mod_sel;
    logic      hi_inv;
    logic      hi_sync;
    dmod_sel_t hi_sel;
    logic      lo_inv;
    logic      lo_sync;
    dmod_sel_t lo_sel;
    dmod_bus_t bus;
    logic [31:0] rdata;
    logic      car_h_q;
    logic      car_l_q;
    logic      hi_act;
    logic      lo_act;
    logic      mod_out;
    logic      stat_s1;
    logic      stat_s2;
  } dmod_state_t;
endpackage

// *** rtl/dmod_sel.sv ***
// Two-stage synchroniser and 16-way source selector
`timescale 1ns/1ps
`include "dmod_consts.svh"
module dmod_sel
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Sources and selection
  input  wire logic [`DMOD_NSRC-1:0] src_in,
  input  wire dmod_pkg::dmod_sel_t   sel,
  // Selected signal, registered
  output logic                       sel_out
);
  import dmod_pkg::*;

  dmod_sel_st_t st_ff;
  dmod_sel_st_t nxt_st;

  // Stage one feeds stage two only; mux reads stage two
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.s1   = src_in;
    nxt_st.s2   = st_ff.s1;
    nxt_st.pick = st_ff.s2[sel];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign sel_out = st_ff.pick;
endmodule

// *** rtl/dmod_top.sv ***
// Data signal modulator with Avalon-MM register slave
`timescale 1ns/1ps
`include "dmod_consts.svh"
// Operation
// - Output mixes the modulator with the carrier active for its level.
// - Disabled: carrier selects forced to ground, modulator to software bit.
// - Synced carrier persists to its falling edge; returning waits for one.
// - Low sync set: wait for low carrier fall before leaving it.
// - High carrier inverted when high invert bit 6 is set.
// - Low carrier inverted by its own invert bit, independently.
// - High sync bit 5: wait for high carrier fall before leaving it.
// - Without sync, carriers switch at once; narrow pulses may appear.
// - Enable bit 7 turns mixing on; cleared gives no output.
// - Output invert bit 4 inverts output so it idles high.
// - Read-only bit 3 shows current output; unreliable for fast signals.
// - Software bit 0 drives modulation only with source code 0000.
// - Modulator source field picks one of sixteen documented sources.
// - High carrier field picks ground, pins, clocks, units or cells.
// - Logic keeps running unchanged while the system sleeps.
// - Any reset disables the modulator and restores register defaults.
// - Control bits clear on reset; selection fields reset too.
// - Unimplemented bits read zero and ignore writes.
module dmod_top
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [3:0]            byteenable,
  input  wire logic [31:0]           writedata,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  // Source vectors, bit index equals select code
  input  wire logic [`DMOD_NSRC-1:0] mod_src_in,
  input  wire logic [`DMOD_NSRC-1:0] carrier_src_in,
  // Modulated output pin
  output logic                       mod_pin_out
);
  import dmod_pkg::*;

  dmod_state_t st_ff;
  dmod_state_t nxt_st;

  logic                  req;
  logic                  wr_go;
  logic [7:0]            wbyte;
  dmod_sel_t             mod_sel_eff;
  dmod_sel_t             hi_sel_eff;
  dmod_sel_t             lo_sel_eff;
  logic [`DMOD_NSRC-1:0] car_vec;
  logic                  mod_pick;
  logic                  hi_pick;
  logic                  lo_pick;
  logic                  mod_sig;
  logic                  car_h;
  logic                  car_l;
  logic                  h_fall;
  logic                  l_fall;
  logic                  mixed;

  // Pack one carrier control byte; unused bits read as zero
  function automatic logic [7:0] car_byte(input logic inv,
                                          input logic sync,
                                          input dmod_sel_t sel);
    car_byte = 8'h00;
    car_byte[`DMOD_CINV_BIT] = inv;
    car_byte[`DMOD_CSYNC_BIT] = sync;
    car_byte[`DMOD_SEL_MSB:0] = sel;
  endfunction

  // Bus handshake: one wait cycle, answer on the second
  assign req         = read | write;
  assign waitrequest = req & (st_ff.bus == BUS_IDLE);
  assign wr_go       = write & ~waitrequest & byteenable[0];
  assign wbyte       = writedata[7:0];
  assign readdata    = st_ff.rdata;

  // Disabled module forces grounded carriers and software data
  assign mod_sel_eff = st_ff.en ? st_ff.mod_sel : `DMOD_SEL_SW;
  assign hi_sel_eff  = st_ff.en ? st_ff.hi_sel : `DMOD_CAR_GND;
  assign lo_sel_eff  = st_ff.en ? st_ff.lo_sel : `DMOD_CAR_GND;

  // Ground and the reserved code carry nothing, whatever is wired
  always_comb
  begin
    car_vec = carrier_src_in;
    car_vec[`DMOD_CAR_GND] = 1'b0;
    car_vec[`DMOD_CAR_RSVD] = 1'b0;
  end

  // Source selectors; external pins are synchronised inside
  dmod_sel u_mod_sel
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .src_in  (mod_src_in),
    .sel     (mod_sel_eff),
    .sel_out (mod_pick)
  );

  dmod_sel u_hi_sel
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .src_in  (car_vec),
    .sel     (hi_sel_eff),
    .sel_out (hi_pick)
  );

  dmod_sel u_lo_sel
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .src_in  (car_vec),
    .sel     (lo_sel_eff),
    .sel_out (lo_pick)
  );

  // Software bit bypasses the synchroniser, it is already local
  assign mod_sig = (mod_sel_eff == `DMOD_SEL_SW) ?
                   st_ff.sw_bit : mod_pick;

  // Per-carrier polarity, each on its own bit
  assign car_h = hi_pick ^ st_ff.hi_inv;
  assign car_l = lo_pick ^ st_ff.lo_inv;

  // Falling edges of the polarised carriers
  assign h_fall = st_ff.car_h_q & ~car_h;
  assign l_fall = st_ff.car_l_q & ~car_l;

  // Each active carrier gated onto the output; disable kills it
  assign mixed = st_ff.en &
                 ((st_ff.hi_act & car_h) |
                  (st_ff.lo_act & car_l));

  // Next-state logic for registers, sync and output
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.car_h_q = car_h;
    nxt_st.car_l_q = car_l;

    // Carrier hand-over; no sleep gating, runs on every edge
    if (mod_sig)
    begin
      // Synced low carrier lingers until its falling edge
      nxt_st.lo_act = st_ff.lo_act & st_ff.lo_sync & ~l_fall;
      // High carrier: at once, or at its next falling edge
      nxt_st.hi_act = st_ff.hi_act | ~st_ff.hi_sync | h_fall;
    end
    else
    begin
      nxt_st.hi_act = st_ff.hi_act & st_ff.hi_sync & ~h_fall;
      nxt_st.lo_act = st_ff.lo_act | ~st_ff.lo_sync | l_fall;
    end

    // Registered pin value, polarity applied last
    nxt_st.mod_out = mixed ^ st_ff.out_inv;

    // Status readback crosses two flops first
    nxt_st.stat_s1 = st_ff.mod_out;
    nxt_st.stat_s2 = st_ff.stat_s1;

    // Bus phase and read capture
    case (st_ff.bus)
      BUS_IDLE:
      begin
        if (req)
        begin
          nxt_st.bus = BUS_ANSWER;
          nxt_st.rdata = 32'h0000_0000;
          if (read)
          begin
            case (address)
              `DMOD_OFS_CTRL:
              begin
                nxt_st.rdata[`DMOD_EN_BIT] = st_ff.en;
                nxt_st.rdata[`DMOD_OINV_BIT] = st_ff.out_inv;
                nxt_st.rdata[`DMOD_STAT_BIT] = st_ff.stat_s2;
                nxt_st.rdata[`DMOD_SWBIT_BIT] = st_ff.sw_bit;
              end
              `DMOD_OFS_SRC:
                nxt_st.rdata[`DMOD_SEL_MSB:0] = st_ff.mod_sel;
              `DMOD_OFS_HIGH_TIME_CARRIER:
                nxt_st.rdata[7:0] = car_byte(st_ff.hi_inv,
                                             st_ff.hi_sync,
                                             st_ff.hi_sel);
              `DMOD_OFS_LOW_TIME_CARRIER:
                nxt_st.rdata[7:0] = car_byte(st_ff.lo_inv,
                                             st_ff.lo_sync,
                                             st_ff.lo_sel);
              default:
                nxt_st.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      BUS_ANSWER:
        nxt_st.bus = BUS_IDLE;
      default:
        nxt_st.bus = BUS_IDLE;
    endcase

    // Writes land on the answering edge; only real bits stored
    if (wr_go)
    begin
      case (address)
        `DMOD_OFS_CTRL:
        begin
          nxt_st.en = wbyte[`DMOD_EN_BIT];
          nxt_st.out_inv = wbyte[`DMOD_OINV_BIT];
          nxt_st.sw_bit = wbyte[`DMOD_SWBIT_BIT];
        end
        `DMOD_OFS_SRC:
          nxt_st.mod_sel = wbyte[`DMOD_SEL_MSB:0];
        `DMOD_OFS_HIGH_TIME_CARRIER:
        begin
          nxt_st.hi_inv = wbyte[`DMOD_CINV_BIT];
          nxt_st.hi_sync = wbyte[`DMOD_CSYNC_BIT];
          nxt_st.hi_sel = wbyte[`DMOD_SEL_MSB:0];
        end
        `DMOD_OFS_LOW_TIME_CARRIER:
        begin
          nxt_st.lo_inv = wbyte[`DMOD_CINV_BIT];
          nxt_st.lo_sync = wbyte[`DMOD_CSYNC_BIT];
          nxt_st.lo_sel = wbyte[`DMOD_SEL_MSB:0];
        end
        default:
          nxt_st.en = st_ff.en;
      endcase
    end
  end

  // State register; a single reset stands for every reset source,
  // so selection fields take a defined zero instead of unknown
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.mod_sel <= `DMOD_SEL_RST;
      st_ff.hi_sel <= `DMOD_SEL_RST;
      st_ff.lo_sel <= `DMOD_SEL_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign mod_pin_out = st_ff.mod_out;

  // Checks on the mixing, sync and bus behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_disabled_idle;
    !st_ff.en |=> mod_pin_out == $past(st_ff.out_inv);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("disabled output not at idle level");

  property p_inverted_high;
    st_ff.en && st_ff.out_inv && st_ff.hi_act && car_h
      |=> !mod_pin_out;
  endproperty
  a_inverted_high: assert property (p_inverted_high)
    else $error("inverted output not low on carrier high");

  property p_no_carrier;
    !st_ff.hi_act && !st_ff.lo_act
      |=> mod_pin_out == $past(st_ff.out_inv);
  endproperty
  a_no_carrier: assert property (p_no_carrier)
    else $error("output active with no active carrier");

  property p_hi_hold;
    st_ff.hi_act && st_ff.hi_sync && !mod_sig && !h_fall
      |=> st_ff.hi_act;
  endproperty
  a_hi_hold: assert property (p_hi_hold)
    else $error("synced high carrier dropped before fall");

  property p_lo_hold;
    st_ff.lo_act && st_ff.lo_sync && mod_sig && !l_fall
      |=> st_ff.lo_act;
  endproperty
  a_lo_hold: assert property (p_lo_hold)
    else $error("synced low carrier dropped before fall");

  // A synced low carrier may still be waiting for its fall
  property p_nosync_drop;
    !mod_sig && !st_ff.hi_sync
      |=> !st_ff.hi_act && (st_ff.lo_act || st_ff.lo_sync);
  endproperty
  a_nosync_drop: assert property (p_nosync_drop)
    else $error("unsynced switch not immediate");

  property p_return_wait;
    !st_ff.hi_act && mod_sig && st_ff.hi_sync && !h_fall
      |=> !st_ff.hi_act;
  endproperty
  a_return_wait: assert property (p_return_wait)
    else $error("synced carrier active before its fall");

  property p_lo_nosync_drop;
    mod_sig && !st_ff.lo_sync
      |=> !st_ff.lo_act && (st_ff.hi_act || st_ff.hi_sync);
  endproperty
  a_lo_nosync_drop: assert property (p_lo_nosync_drop)
    else $error("unsynced low carrier not dropped at once");

  property p_low_on;
    st_ff.en && !st_ff.out_inv && st_ff.lo_act && car_l
      |=> mod_pin_out;
  endproperty
  a_low_on: assert property (p_low_on)
    else $error("active low carrier high but output low");

  property p_status_lag;
    st_ff.mod_out [*2] |=> st_ff.stat_s2;
  endproperty
  a_status_lag: assert property (p_status_lag)
    else $error("status does not follow output");

  property p_sw_source;
    !st_ff.en |-> mod_sig == st_ff.sw_bit;
  endproperty
  a_sw_source: assert property (p_sw_source)
    else $error("disabled modulator not on software bit");

  property p_one_wait;
    req && waitrequest |=> !waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("waitrequest held longer than one cycle");

  c_hi_hold: cover property (st_ff.hi_sync && !mod_sig &&
                             st_ff.hi_act ##1 !st_ff.hi_act);
  c_lo_hold: cover property (st_ff.lo_sync && mod_sig &&
                             st_ff.lo_act ##1 !st_ff.lo_act);
  c_out_high: cover property (st_ff.en && mod_pin_out);
  c_write: cover property (wr_go);
endmodule

// *** verif/dmod_src_model.sv ***
// Source model: static levels or one shared square-wave carrier
`timescale 1ns/1ps
module dmod_src_model
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Bench controls
  input  wire logic        run,
  input  wire logic [7:0]  half,
  input  wire logic [15:0] mod_lvl,
  input  wire logic [15:0] car_lvl,
  // Source vectors, bit index equals select code
  output logic [15:0]      mod_src_in,
  output logic [15:0]      carrier_src_in
);
  logic [7:0] cnt_ff;
  logic       wave_ff;
  // Wave stands still at 0 while stopped, so edges are known
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= 8'h00;
      wave_ff <= 1'b0;
    end
    else if (!run)
    begin
      cnt_ff  <= 8'h00;
      wave_ff <= 1'b0;
    end
    else if (cnt_ff == half)
    begin
      cnt_ff  <= 8'h00;
      wave_ff <= ~wave_ff;
    end
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
  // Running: every carrier source shows the wave
  assign carrier_src_in = run ? {16{wave_ff}} : car_lvl;
  assign mod_src_in     = mod_lvl;
endmodule

// *** verif/test_data_signal_modulator.sv ***
// Self-checking bench for the data signal modulator
`timescale 1ns/1ps
`include "dmod_consts.svh"
module test_data_signal_modulator;
  import dmod_pkg::*;
  logic        mclk       = 1'b0;
  logic        rst_n      = 1'b0;
  logic [3:0]  address    = 4'h0;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata  = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [15:0] mod_src_in;
  logic [15:0] carrier_src_in;
  logic        mod_pin_out;
  logic        run        = 1'b0;
  logic [15:0] mod_lvl    = 16'h0;
  logic [15:0] car_lvl    = 16'h0;
  logic [7:0]  q;
  logic [7:0]  wd [4]     = '{8'h6E, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  rm [4]     = '{8'h00, 8'h0F, 8'h6F, 8'h6F};
  logic [31:0] cor [3]    = '{32'h19090, 32'h0C000, 32'h04000};
  int          fails      = 0;
  int          num_checks = 0;
  int          seed       = 49;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  dmod_top dut (.mclk(mclk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .mod_src_in(mod_src_in),
    .carrier_src_in(carrier_src_in), .mod_pin_out(mod_pin_out));
  // Slow carrier: 20 cycles high, 20 low
  dmod_src_model src (.mclk(mclk), .rst_n(rst_n), .run(run),
    .half(8'h13), .mod_lvl(mod_lvl), .car_lvl(car_lvl),
    .mod_src_in(mod_src_in), .carrier_src_in(carrier_src_in));

  task automatic results();
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tmo();
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t pin %b want %b", $time, g, e);
    end
  endtask
  // Request held until waitrequest is seen low before an edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] rq);
    int n;
    n = 0;
    @(posedge mclk);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= {24'h000000, d};
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20)
      tmo();
    // Data taken at the edge that sees waitrequest low, then released
    rq = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] j;
    bus(1'b1, a, d, j);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] rq);
    bus(1'b0, a, 8'h00, rq);
  endtask
  function automatic logic car(logic [3:0] s, logic [15:0] cv);
    return (s == 4'h0 || s == 4'h9) ? 1'b0 : cv[s];
  endfunction
  // Fields: ms 3:0, hs 7:4, ls 11:8, hinv 12, linv 13,
  // oinv 14, en 15, sw 16
  function automatic logic exp_pin(logic [31:0] r, logic [15:0] mv,
                                   logic [15:0] cv);
    logic m;
    logic h;
    logic l;
    m = (r[3:0] == 4'h0) ? r[16] : mv[r[3:0]];
    h = car(r[7:4], cv) ^ r[12];
    l = car(r[11:8], cv) ^ r[13];
    return r[15] ? ((m ? h : l) ^ r[14]) : r[14];
  endfunction
  // Static sources, no sync: output settles to the mixed level
  task automatic apply(input logic [31:0] r, input logic [15:0] mv,
                       input logic [15:0] cv);
    logic e;
    mod_lvl <= mv;
    car_lvl <= cv;
    wr(`DMOD_OFS_SRC, {4'h0, r[3:0]});
    wr(`DMOD_OFS_HIGH_TIME_CARRIER, {1'b0, r[12], 2'b00, r[7:4]});
    wr(`DMOD_OFS_LOW_TIME_CARRIER, {1'b0, r[13], 2'b00, r[11:8]});
    wr(`DMOD_OFS_CTRL, {r[15], 2'b00, r[14], 3'b000, r[16]});
    e = exp_pin(r, mv, cv);
    repeat (10) @(posedge mclk);
    chk_pin(mod_pin_out, e);
    rd(`DMOD_OFS_CTRL, q);
    chk_reg(q, {r[15], 2'b00, r[14], e, 2'b00, r[16]});
  endtask
  task automatic wait_rise();
    logic p;
    int   n;
    p = 1'b1;
    n = 0;
    while (!(p === 1'b0 && carrier_src_in[1] === 1'b1) && n < 100)
    begin
      p = carrier_src_in[1];
      @(negedge mclk);
      n++;
    end
    if (n >= 100)
      tmo();
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // Defaults, then only implemented bits hold
    for (int i = 0; i < 4; i++)
    begin
      rd(4'(4 * i), q);
      chk_reg(q, 8'h00);
      wr(4'(4 * i), wd[i]);
      rd(4'(4 * i), q);
      chk_reg(q, rm[i]);
    end
    // Unmapped place and masked byte lane change nothing
    wr(4'h2, 8'hFF);
    rd(4'h2, q);
    chk_reg(q, 8'h00);
    byteenable <= 4'h0;
    wr(`DMOD_OFS_SRC, 8'h03);
    byteenable <= 4'hF;
    rd(`DMOD_OFS_SRC, q);
    chk_reg(q, 8'h0F);
    // Hand-written corners: reserved code, ground, disabled
    for (int i = 0; i < 3; i++)
      apply(cor[i], 16'hFFFF, 16'hFFFF);
    // Every source code for modulator and both carriers
    for (int k = 0; k < 16; k++)
      apply(32'h18000 | k | (k << 4) | ((15 - k) << 8),
            $random(seed), $random(seed));
    for (int k = 0; k < 30; k++)
      apply($random(seed) & 32'h1FFFF, $random(seed), $random(seed));
    // Switch off a carrier just after it rose, sync off and on
    for (int i = 0; i < 4; i++)
    begin
      run <= 1'b0;
      wr(`DMOD_OFS_CTRL, 8'h00);
      wr(`DMOD_OFS_SRC, 8'h00);
      wr(`DMOD_OFS_HIGH_TIME_CARRIER, i[1] ? 8'h00 : {2'b00, i[0], 5'h01});
      wr(`DMOD_OFS_LOW_TIME_CARRIER, i[1] ? {2'b00, i[0], 5'h01} : 8'h00);
      run <= 1'b1;
      wr(`DMOD_OFS_CTRL, {1'b1, 6'h00, ~i[1]});
      // A synced carrier only takes over after a fall, so pass one
      repeat (2) wait_rise();
      wr(`DMOD_OFS_CTRL, {1'b1, 6'h00, i[1]});
      repeat (12) @(posedge mclk);
      chk_pin(mod_pin_out, i[0]);
    end
    // Reset in mid-run
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_pin(mod_pin_out, 1'b0);
    rst_n <= 1'b1;
    rd(`DMOD_OFS_CTRL, q);
    chk_reg(q, 8'h00);
    results();
  end
endmodule
